// *** design/cvd_acq_pkg.sv ***
// Package with register map, field layout and timing constants for the acquisition and guard block.
package cvd_acq_pkg;
    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [11:0] ACQ_OFFSET    = 12'h000;
    localparam logic [11:0] GUARD_OFFSET  = 12'h004;
    localparam logic [11:0] CTRL_OFFSET   = 12'h008;
    localparam logic [11:0] STATUS_OFFSET = 12'h00C;

    // ------------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------------
    localparam int unsigned DUR_W     = 7;
    localparam int unsigned GRD_B_BIT = 7;
    localparam int unsigned GRD_A_BIT = 6;
    localparam int unsigned GRD_P_BIT = 5;
    localparam logic [7:0]  ACQ_MASK  = 8'h7F;
    localparam logic [7:0]  GRD_MASK  = 8'hE0;
    localparam logic [7:0]  REG_RESET = 8'h00;
    localparam logic [DUR_W-1:0] DUR_ZERO = 7'h00;
    localparam logic [DUR_W-1:0] DUR_ONE  = 7'h01;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    // Instruction cycle is one quarter of the main oscillator (Fosc/4).
    localparam int unsigned INSTR_DIV = 4;
    localparam logic [1:0]  PRESC_LAST = 2'(INSTR_DIV - 1);

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ACQ  = 2'b01,
        ST_DONE = 2'b10
    } acq_state_t;
endpackage

// *** design/cvd_tick_gen.sv ***
// Timing-tick generator: instruction-cycle tick or synchronous RC-clock tick.
`timescale 1ns/1ps
module cvd_tick_gen (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic use_rc_clock,
    input  wire logic rc_clock_tick,
    output logic      tick
);
    logic [1:0] presc;
    logic [1:0] next_presc;
    logic       next_tick;

    always_comb begin
        next_presc = (presc == cvd_acq_pkg::PRESC_LAST) ? 2'h0 : presc + 2'h1;
        if (use_rc_clock) begin
            next_tick = rc_clock_tick; // RULE_04
        end else begin
            next_tick = (presc == cvd_acq_pkg::PRESC_LAST); // RULE_03
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            presc <= 2'h0;
            tick  <= 1'b0;
        end else begin
            presc <= next_presc;
            tick  <= next_tick;
        end
    end
endmodule

// *** design/cvd_acquisition_guard_timing.sv ***
// Acquisition timer and guard-ring control with an APB register slave.
//
// Contract
// [RULE_01] Nonzero duration N holds acquisition for exactly N timing cycles, up to 127; the code ends it on the Nth tick, up to one cycle short.
// [RULE_02] Zero duration skips the acquisition phase entirely.
// [RULE_03] Timing cycle is the instruction cycle, one quarter of the oscillator.
// [RULE_04] Selecting the internal RC conversion clock times the phases from it instead.
// [RULE_05] Unimplemented register bits read zero and ignore writes.
// [RULE_06] All writable bits clear to zero on every reset.
// [RULE_07] Enable B drives guard signal onto pin B; software sets pin direction output.
// [RULE_08] Enable A drives guard signal onto pin A; software sets pin direction output.
// [RULE_09] Guard outputs start high in precharge if polarity is one, else low.
// [RULE_10] Guard A toggles at acquisition start; guards stay active while converter enabled.
// [RULE_11] Duration loads a down-counter at stage start; zero signals stage done.
`timescale 1ns/1ps
module cvd_acquisition_guard_timing (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        converter_enable,
    input  wire logic        precharge_active,
    input  wire logic        acq_stage_start,
    input  wire logic        rc_clock_tick,
    output logic             acq_stage_done,
    output logic             acq_active,
    output logic             guard_pin_a,
    output logic             guard_pin_a_oe,
    output logic             guard_pin_b,
    output logic             guard_pin_b_oe,
    output logic             use_rc_clock_o
);
    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [7:0] acquisition_time_control;
    logic [7:0] guard_ring_control;
    logic       use_rc_clock;
    logic [7:0] next_acq_reg;
    logic [7:0] next_grd_reg;
    logic       next_use_rc;
    logic [31:0] next_prdata;
    logic        next_pready;
    logic        next_pslverr;
    logic        tick;
    // The remaining count is read back through the status word, so it is declared here.
    logic [cvd_acq_pkg::DUR_W-1:0] count;

    wire setup  = psel && !penable;
    wire access = psel && penable && pready;
    // Status is read only; a write to it is accepted and ignored rather than flagged.
    wire mapped = (paddr == cvd_acq_pkg::ACQ_OFFSET) || (paddr == cvd_acq_pkg::GUARD_OFFSET) ||
                  (paddr == cvd_acq_pkg::CTRL_OFFSET) || (paddr == cvd_acq_pkg::STATUS_OFFSET);

    // Slave answers one cycle after setup: pready rises in the first access cycle.
    always_comb begin
        next_acq_reg = acquisition_time_control;
        next_grd_reg = guard_ring_control;
        next_use_rc  = use_rc_clock;
        next_pready  = setup;
        next_pslverr = setup && !mapped;
        next_prdata  = prdata;
        if (setup && !pwrite) begin
            unique case (paddr)
                cvd_acq_pkg::ACQ_OFFSET:    next_prdata = {24'h00_0000, acquisition_time_control};
                cvd_acq_pkg::GUARD_OFFSET:  next_prdata = {24'h00_0000, guard_ring_control};
                cvd_acq_pkg::CTRL_OFFSET:   next_prdata = {31'h0000_0000, use_rc_clock};
                cvd_acq_pkg::STATUS_OFFSET: next_prdata = {24'h00_0000, acq_active, count};
                default:                    next_prdata = 32'h0000_0000;
            endcase
        end
        // Writes return zero so a write answer never exposes the last read word.
        if (setup && pwrite) begin
            next_prdata = 32'h0000_0000;
        end
        if (access && pwrite) begin
            unique case (paddr)
                cvd_acq_pkg::ACQ_OFFSET:   next_acq_reg = pwdata[7:0] & cvd_acq_pkg::ACQ_MASK; // RULE_05
                cvd_acq_pkg::GUARD_OFFSET: next_grd_reg = pwdata[7:0] & cvd_acq_pkg::GRD_MASK; // RULE_05
                cvd_acq_pkg::CTRL_OFFSET:  next_use_rc  = pwdata[0];
                default:                   next_use_rc  = use_rc_clock;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            acquisition_time_control <= cvd_acq_pkg::REG_RESET; // RULE_06
            guard_ring_control       <= cvd_acq_pkg::REG_RESET; // RULE_06
            use_rc_clock             <= 1'b0;
            use_rc_clock_o           <= 1'b0;
            prdata                   <= 32'h0000_0000;
            pready                   <= 1'b0;
            pslverr                  <= 1'b0;
        end else begin
            acquisition_time_control <= next_acq_reg;
            guard_ring_control       <= next_grd_reg;
            use_rc_clock             <= next_use_rc;
            use_rc_clock_o           <= next_use_rc;
            prdata                   <= next_prdata;
            pready                   <= next_pready;
            pslverr                  <= next_pslverr;
        end
    end

    cvd_tick_gen u_tick (
        .clk           (clk),
        .rst_n         (rst_n),
        .use_rc_clock  (use_rc_clock), // RULE_04
        .rc_clock_tick (rc_clock_tick),
        .tick          (tick)
    );

    // ------------------------------------------------------------------
    // Acquisition timer
    // ------------------------------------------------------------------
    // The counter counts from the first tick after start, so a phase ends on the Nth
    // tick; the start may fall mid-cycle, so the first tick is partial and the phase is up to one tick short.
    cvd_acq_pkg::acq_state_t state;
    cvd_acq_pkg::acq_state_t next_state;
    logic [cvd_acq_pkg::DUR_W-1:0] next_count;
    logic                          next_done;
    wire  [cvd_acq_pkg::DUR_W-1:0] duration = acquisition_time_control[cvd_acq_pkg::DUR_W-1:0];

    always_comb begin
        next_state = state;
        next_count = count;
        next_done  = 1'b0;
        unique case (state)
            cvd_acq_pkg::ST_IDLE: begin
                if (acq_stage_start && converter_enable) begin
                    if (duration == cvd_acq_pkg::DUR_ZERO) begin
                        next_done = 1'b1; // RULE_02
                    end else begin
                        next_count = duration; // RULE_11
                        next_state = cvd_acq_pkg::ST_ACQ;
                    end
                end
            end
            cvd_acq_pkg::ST_ACQ: begin
                // Switching the converter off abandons the phase without a done pulse;
                // the sequencer must issue a fresh start once the converter is back on.
                if (!converter_enable) begin
                    next_state = cvd_acq_pkg::ST_IDLE;
                    next_count = cvd_acq_pkg::DUR_ZERO;
                end else if (tick) begin
                    next_count = count - cvd_acq_pkg::DUR_ONE; // RULE_01
                    if (count == cvd_acq_pkg::DUR_ONE) begin
                        next_state = cvd_acq_pkg::ST_DONE; // RULE_11
                        next_done  = 1'b1;
                    end
                end
            end
            cvd_acq_pkg::ST_DONE: begin
                next_state = cvd_acq_pkg::ST_IDLE;
            end
            default: begin
                next_state = cvd_acq_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state          <= cvd_acq_pkg::ST_IDLE;
            count          <= cvd_acq_pkg::DUR_ZERO;
            acq_stage_done <= 1'b0;
            acq_active     <= 1'b0;
        end else begin
            state          <= next_state;
            count          <= next_count;
            acq_stage_done <= next_done;
            acq_active     <= (next_state == cvd_acq_pkg::ST_ACQ);
        end
    end

    // ------------------------------------------------------------------
    // Guard ring outputs
    // ------------------------------------------------------------------
    logic next_ga;
    logic next_gb;
    logic next_ga_oe;
    logic next_gb_oe;
    wire  pol = guard_ring_control[cvd_acq_pkg::GRD_P_BIT];

    // Only guard A flips for acquisition; inverting both guards for a second,
    // inverted sample is not handled here and is left to the sequencer.

    always_comb begin
        next_ga    = 1'b0;
        next_gb    = 1'b0;
        next_ga_oe = guard_ring_control[cvd_acq_pkg::GRD_A_BIT] && converter_enable; // RULE_08 RULE_10
        next_gb_oe = guard_ring_control[cvd_acq_pkg::GRD_B_BIT] && converter_enable; // RULE_07 RULE_10
        if (converter_enable) begin
            next_ga = pol; // RULE_09
            next_gb = pol; // RULE_09
            if (next_state == cvd_acq_pkg::ST_ACQ && !precharge_active) begin
                next_ga = !pol; // RULE_10
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            guard_pin_a    <= 1'b0;
            guard_pin_b    <= 1'b0;
            guard_pin_a_oe <= 1'b0;
            guard_pin_b_oe <= 1'b0;
        end else begin
            guard_pin_a    <= next_ga;
            guard_pin_b    <= next_gb;
            guard_pin_a_oe <= next_ga_oe;
            guard_pin_b_oe <= next_gb_oe;
        end
    end
endmodule

// *** test/cvd_acq_props.sv ***
// Checker with concurrent properties for the acquisition and guard block.
`timescale 1ns/1ps
module cvd_acq_props (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        converter_enable,
    input wire logic        precharge_active,
    input wire logic        acq_active,
    input wire logic        acq_stage_done,
    input wire logic        guard_pin_a,
    input wire logic        guard_pin_b,
    input wire logic        guard_pin_a_oe,
    input wire logic        guard_pin_b_oe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    apb_ready_a: assert property (psel && !penable |=> pready) else $error("pready late");
    ready_pulse_a: assert property (pready |=> !pready) else $error("pready too long");
    unmapped_err_a: assert property (pready && paddr > 12'h00C |-> pslverr && prdata == 32'h0) else $error("no error");
    acq_rdzero_a: assert property (pready && !pwrite && paddr == cvd_acq_pkg::ACQ_OFFSET
        |-> prdata[31:7] == 25'h0) else $error("acq high bits");
    grd_rdzero_a: assert property (pready && !pwrite && paddr == cvd_acq_pkg::GUARD_OFFSET
        |-> prdata[31:8] == 24'h0 && prdata[4:0] == 5'h0) else $error("guard low bits");
    oe_a_gate_a: assert property (guard_pin_a_oe |-> $past(converter_enable)) else $error("oe a");
    oe_b_gate_a: assert property (guard_pin_b_oe |-> $past(converter_enable)) else $error("oe b");
    // Guard A differs from guard B exactly while acquiring, once inputs are steady.
    guard_flip_a: assert property (converter_enable && $past(converter_enable) && !precharge_active
        && !$past(precharge_active) |-> (guard_pin_a != guard_pin_b) == acq_active) else $error("guard a");
    done_pulse_a: assert property (acq_stage_done |=> !acq_stage_done) else $error("done pulse");
    done_ends_a: assert property (acq_stage_done |-> !acq_active) else $error("done active");
    acq_bound_a: assert property ($rose(acq_active) |-> ##[1:1000] !acq_active) else $error("acq hang");
    done_c: cover property (acq_stage_done);
    err_c: cover property (pready && pslverr);
    acq_c: cover property ($rose(acq_active));
endmodule

// *** test/cvd_acquisition_guard_timing_tb.sv ***
// Testbench for the acquisition timer and guard block.
`timescale 1ns/1ps
module cvd_acquisition_guard_timing_tb;
    logic        clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, pol = 0, e;
    logic        converter_enable = 0, precharge_active = 0, acq_stage_start = 0, rc_clock_tick = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, q;
    logic        pready, pslverr, acq_stage_done, acq_active, use_rc_clock_o;
    logic        guard_pin_a, guard_pin_a_oe, guard_pin_b, guard_pin_b_oe;
    int          n_mismatch = 0, checked = 0, rc_cnt = 0;
    int          durs[4] = '{0, 1, 2, 127};

    cvd_acquisition_guard_timing dut_u (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .converter_enable(converter_enable), .precharge_active(precharge_active),
        .acq_stage_start(acq_stage_start), .rc_clock_tick(rc_clock_tick), .acq_stage_done(acq_stage_done),
        .acq_active(acq_active), .guard_pin_a(guard_pin_a), .guard_pin_a_oe(guard_pin_a_oe),
        .guard_pin_b(guard_pin_b), .guard_pin_b_oe(guard_pin_b_oe), .use_rc_clock_o(use_rc_clock_o));

    always #5 clk = ~clk;
    // The RC clock runs free at one tick every ten cycles; it only matters once selected.
    always @(posedge clk) begin
        rc_cnt <= (rc_cnt == 9) ? 0 : rc_cnt + 1;
        rc_clock_tick <= (rc_cnt == 9);
    end

    task finish_test;
        if (n_mismatch == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (pready !== 1 && i < 50);
        if (pready !== 1) begin
            n_mismatch++;
            finish_test;
        end
        q = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
    endtask

    task rd(input logic [11:0] a, input logic [31:0] x, input string n);
        apb(0, a, 32'h0000_0000);
        chk(n, q, x);
    endtask

    task run(input int lo, input int hi);
        int c;
        @(posedge clk);
        acq_stage_start <= 1;
        @(posedge clk);
        acq_stage_start <= 0;
        c = 0;
        while (acq_stage_done !== 1 && c < 2000) begin
            if (acq_active === 1) chk("guard_a_acq", 32'(guard_pin_a), 32'(!pol));
            @(posedge clk);
            c++;
        end
        if (c >= 2000) begin
            n_mismatch++;
            finish_test;
        end
        chk("dur_low", 32'(c >= lo), 32'h0000_0001);
        chk("dur_high", 32'(c <= hi), 32'h0000_0001);
    endtask

    task guards(input logic v, input logic oe);
        repeat (3) @(posedge clk);
        chk("guard_a", 32'(guard_pin_a), 32'(v));
        chk("guard_b", 32'(guard_pin_b), 32'(v));
        chk("oe_a", 32'(guard_pin_a_oe), 32'(oe));
        chk("oe_b", 32'(guard_pin_b_oe), 32'(oe));
    endtask

    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1;
        rd(cvd_acq_pkg::ACQ_OFFSET, 32'h0000_0000, "acq_rst");
        rd(cvd_acq_pkg::GUARD_OFFSET, 32'h0000_0000, "guard_rst");
        apb(1, cvd_acq_pkg::ACQ_OFFSET, 32'h0000_00FF);
        rd(cvd_acq_pkg::ACQ_OFFSET, 32'h0000_007F, "acq_mask");
        apb(1, cvd_acq_pkg::GUARD_OFFSET, 32'h0000_001F);
        rd(cvd_acq_pkg::GUARD_OFFSET, 32'h0000_0000, "guard_mask");
        apb(1, 12'h020, 32'h0000_0001);
        rd(12'h010, 32'h0000_0000, "unmapped");
        chk("unmapped_err", 32'(e), 32'h0000_0001);
        converter_enable <= 1;
        pol = 1;
        apb(1, cvd_acq_pkg::GUARD_OFFSET, 32'h0000_00E0);
        guards(1, 1);
        foreach (durs[k]) begin
            apb(1, cvd_acq_pkg::ACQ_OFFSET, 32'(durs[k]));
            run(durs[k] == 0 ? 1 : 4 * durs[k] - 3, durs[k] == 0 ? 2 : 4 * durs[k] + 2);
        end
        converter_enable <= 0;
        guards(0, 0);
        converter_enable <= 1;
        pol = 0;
        apb(1, cvd_acq_pkg::GUARD_OFFSET, 32'h0000_0000);
        guards(0, 0);
        apb(1, cvd_acq_pkg::ACQ_OFFSET, 32'h0000_0003);
        run(9, 14);
        apb(1, cvd_acq_pkg::CTRL_OFFSET, 32'h0000_0001);
        repeat (2) @(posedge clk);
        chk("rc_sel", 32'(use_rc_clock_o), 32'h0000_0001);
        run(18, 33);
        rst_n <= 0;
        repeat (2) @(posedge clk);
        rst_n <= 1;
        rd(cvd_acq_pkg::ACQ_OFFSET, 32'h0000_0000, "acq_rst2");
        rd(cvd_acq_pkg::CTRL_OFFSET, 32'h0000_0000, "ctrl_rst2");
        finish_test;
    end
endmodule

bind cvd_acquisition_guard_timing cvd_acq_props props_u (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .converter_enable(converter_enable), .precharge_active(precharge_active), .acq_active(acq_active),
    .acq_stage_done(acq_stage_done), .guard_pin_a(guard_pin_a), .guard_pin_b(guard_pin_b),
    .guard_pin_a_oe(guard_pin_a_oe), .guard_pin_b_oe(guard_pin_b_oe));
